// [verilog/adc_start_pkg.sv]
// Summary of operation
// - Set done flag when conversion finishes
// - Done flag stays clear until next completion
// - Done flag sets on active bit falling edge
// - Active bit reads one while converting
// - Software start only with source code zero
// - Window flag sets on match, sticky
// - Three-bit source field in bits two..zero
// - Code 000 starts on a software write with bit four set
// - Code 001 starts on timer0 overflow
// - Code 011 timer1 overflow, tracking first
// - Code 101 starts on timer3 overflow
// - Track mode bit six selects low-power tracking
// - Low-power tracking lasts three SAR clocks
// - Code 100 tracks while strobe low
// - Code 100 converts on strobe rising edge
package adc_start_pkg;

  // ****************************************
  // Register map
  // ****************************************
  localparam logic [1:0] ADDR_CTRL = 2'h0;
  localparam logic [1:0] ADDR_CLEAR = 2'h1;

  // Control/status register bit positions
  localparam int BIT_TRACK_MODE = 6;
  localparam int BIT_DONE = 5;
  localparam int BIT_ACTIVE = 4;
  localparam int BIT_WINDOW = 3;
  localparam int SRC_MSB = 2;
  localparam logic [7:0] CTRL_RESET = 8'h00;

  // ****************************************
  // Timing
  // ****************************************
  localparam int TRACK_SAR_CLKS = 3;
  localparam logic [1:0] TRACK_LAST = 2'(TRACK_SAR_CLKS - 1);

  // ****************************************
  // Types
  // ****************************************
  typedef enum logic [2:0] {
    SRC_SOFTWARE = 3'b000,
    SRC_TIMER0 = 3'b001,
    SRC_TIMER2 = 3'b010,
    SRC_TIMER1 = 3'b011,
    SRC_STROBE = 3'b100,
    SRC_TIMER3 = 3'b101,
    SRC_RSVD6 = 3'b110,
    SRC_RSVD7 = 3'b111
  } start_source_select_t;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_TRACK = 2'b01,
    ST_CONVERT = 2'b10
  } conv_state_t;

  typedef struct packed {
    logic timer0_ovf;
    logic timer1_ovf;
    logic timer2_ovf;
    logic timer3_ovf;
  } timer_ovf_t;

  typedef struct packed {
    logic [1:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } reg_req_t;

endpackage : adc_start_pkg

// [verilog/adc_conversion_start_control.sv]
// Implementation choices: the strobed register port and the placing of the registers.
`timescale 1ns/100ps
module adc_conversion_start_control
(
  input wire logic core_clk,
  input wire logic rst,
  input adc_start_pkg::reg_req_t reg_req,
  output logic [7:0] reg_rdata,
  input adc_start_pkg::timer_ovf_t timer_ovf,
  input wire logic ext_convert_strobe,
  input wire logic sar_clk_tick,
  input wire logic conv_finished,
  input wire logic window_hit,
  output logic track_q_out,
  output logic convert_start,
  output logic conv_active_bit
);

  // ****************************************
  // Strobe synchroniser and edge detect
  // ****************************************
  logic strobe_meta_q, strobe_sync_q, strobe_prev_q;
  logic strobe_meta_d, strobe_sync_d, strobe_prev_d;
  logic strobe_rise;

  always_comb
  begin
    strobe_meta_d = ext_convert_strobe;
    strobe_sync_d = strobe_meta_q;
    strobe_prev_d = strobe_sync_q;
    strobe_rise = strobe_sync_q & ~strobe_prev_q;
  end

  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      strobe_meta_q <= 1'b1;
      strobe_sync_q <= 1'b1;
      strobe_prev_q <= 1'b1;
    end
    else
    begin
      strobe_meta_q <= strobe_meta_d;
      strobe_sync_q <= strobe_sync_d;
      strobe_prev_q <= strobe_prev_d;
    end
  end

  // ****************************************
  // Control register and sequencer
  // ****************************************
  logic track_mode_select_q, track_mode_select_d;
  logic [2:0] start_source_select_q, start_source_select_d;
  logic conv_done_flag_q, conv_done_flag_d;
  logic window_match_flag_q, window_match_flag_d;
  adc_start_pkg::conv_state_t state_q, state_d;
  logic [1:0] track_cnt_q, track_cnt_d;
  logic [7:0] rdata_q, rdata_d;
  logic start_q, start_d;
  logic track_q, track_d;
  logic active_q, active_d;
  logic sw_write, sw_start, trigger, ctrl_wr, clr_wr;
  adc_start_pkg::start_source_select_t src;

  always_comb
  begin
    src = adc_start_pkg::start_source_select_t'(start_source_select_q);
    ctrl_wr = reg_req.wr && (reg_req.addr == adc_start_pkg::ADDR_CTRL);
    clr_wr = reg_req.wr && (reg_req.addr == adc_start_pkg::ADDR_CLEAR);
    sw_write = ctrl_wr && reg_req.wdata[adc_start_pkg::BIT_ACTIVE];
    // Writing 0 never starts anything
    sw_start = sw_write && (src == adc_start_pkg::SRC_SOFTWARE);
    case (src)
      adc_start_pkg::SRC_SOFTWARE: trigger = sw_start;
      adc_start_pkg::SRC_TIMER0: trigger = timer_ovf.timer0_ovf;
      adc_start_pkg::SRC_TIMER2: trigger = timer_ovf.timer2_ovf;
      adc_start_pkg::SRC_TIMER1: trigger = timer_ovf.timer1_ovf;
      adc_start_pkg::SRC_STROBE: trigger = strobe_rise;
      adc_start_pkg::SRC_TIMER3: trigger = timer_ovf.timer3_ovf;
      default: trigger = 1'b0;
    endcase

    track_mode_select_d = track_mode_select_q;
    start_source_select_d = start_source_select_q;
    if (ctrl_wr)
    begin
      track_mode_select_d = reg_req.wdata[adc_start_pkg::BIT_TRACK_MODE];
      start_source_select_d = reg_req.wdata[adc_start_pkg::SRC_MSB:0];
    end

    state_d = state_q;
    track_cnt_d = track_cnt_q;
    start_d = 1'b0;
    case (state_q)
      adc_start_pkg::ST_IDLE:
        if (trigger)
        begin
          // Strobe mode already tracked while pin was low
          if (track_mode_select_q && (src != adc_start_pkg::SRC_STROBE))
          begin
            state_d = adc_start_pkg::ST_TRACK;
            track_cnt_d = 2'h0;
          end
          else
          begin
            state_d = adc_start_pkg::ST_CONVERT;
            start_d = 1'b1;
          end
        end
      adc_start_pkg::ST_TRACK:
        if (sar_clk_tick)
        begin
          if (track_cnt_q == adc_start_pkg::TRACK_LAST)
          begin
            state_d = adc_start_pkg::ST_CONVERT;
            start_d = 1'b1;
          end
          else
            track_cnt_d = track_cnt_q + 2'h1;
        end
      adc_start_pkg::ST_CONVERT:
        if (conv_finished)
          state_d = adc_start_pkg::ST_IDLE;
      default: state_d = adc_start_pkg::ST_IDLE;
    endcase

    active_d = (state_d != adc_start_pkg::ST_IDLE);
    // Normal mode tracks whenever idle; low-power only in its phase
    if (track_mode_select_d && (start_source_select_d == 3'(adc_start_pkg::SRC_STROBE)))
      track_d = (state_d == adc_start_pkg::ST_IDLE) && !strobe_sync_q;
    else if (track_mode_select_d)
      track_d = (state_d == adc_start_pkg::ST_TRACK);
    else
      track_d = (state_d == adc_start_pkg::ST_IDLE);

    // Hardware set wins over a software clear in the same cycle
    conv_done_flag_d = conv_done_flag_q;
    window_match_flag_d = window_match_flag_q;
    if (clr_wr && reg_req.wdata[adc_start_pkg::BIT_DONE])
      conv_done_flag_d = 1'b0;
    if (clr_wr && reg_req.wdata[adc_start_pkg::BIT_WINDOW])
      window_match_flag_d = 1'b0;
    if ((state_q == adc_start_pkg::ST_CONVERT) && conv_finished)
      conv_done_flag_d = 1'b1;
    if (window_hit)
      window_match_flag_d = 1'b1;

    rdata_d = 8'h00;
    if (reg_req.rd && (reg_req.addr == adc_start_pkg::ADDR_CTRL))
    begin
      rdata_d[adc_start_pkg::BIT_TRACK_MODE] = track_mode_select_q;
      rdata_d[adc_start_pkg::BIT_DONE] = conv_done_flag_q;
      rdata_d[adc_start_pkg::BIT_ACTIVE] = active_q;
      rdata_d[adc_start_pkg::BIT_WINDOW] = window_match_flag_q;
      rdata_d[adc_start_pkg::SRC_MSB:0] = start_source_select_q;
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      track_mode_select_q <= adc_start_pkg::CTRL_RESET[adc_start_pkg::BIT_TRACK_MODE];
      start_source_select_q <= adc_start_pkg::CTRL_RESET[adc_start_pkg::SRC_MSB:0];
      conv_done_flag_q <= 1'b0;
      window_match_flag_q <= 1'b0;
      state_q <= adc_start_pkg::ST_IDLE;
      track_cnt_q <= 2'h0;
      rdata_q <= 8'h00;
      start_q <= 1'b0;
      track_q <= 1'b0;
      active_q <= 1'b0;
    end
    else
    begin
      track_mode_select_q <= track_mode_select_d;
      start_source_select_q <= start_source_select_d;
      conv_done_flag_q <= conv_done_flag_d;
      window_match_flag_q <= window_match_flag_d;
      state_q <= state_d;
      track_cnt_q <= track_cnt_d;
      rdata_q <= rdata_d;
      start_q <= start_d;
      track_q <= track_d;
      active_q <= active_d;
    end
  end

  assign reg_rdata = rdata_q;
  assign convert_start = start_q;
  assign track_q_out = track_q;
  assign conv_active_bit = active_q;

endmodule : adc_conversion_start_control

// [test/adc_start_checker.sv]
`timescale 1ns/100ps
module adc_start_checker
(
  input wire logic core_clk,
  input wire logic rst,
  input adc_start_pkg::reg_req_t reg_req,
  input wire logic [7:0] reg_rdata,
  input adc_start_pkg::timer_ovf_t timer_ovf,
  input wire logic ext_convert_strobe,
  input wire logic sar_clk_tick,
  input wire logic conv_finished,
  input wire logic window_hit,
  input wire logic track_q_out,
  input wire logic convert_start,
  input wire logic conv_active_bit
);
  // ****
  // Ticks counted while a busy tracking phase runs
  // ****
  logic [2:0] ticks_q;
  logic [2:0] ticks_d;
  always_comb ticks_d = !conv_active_bit ? 3'h0 : ticks_q + 3'(sar_clk_tick && track_q_out);
  always_ff @(posedge core_clk) ticks_q <= rst ? 3'h0 : ticks_d;
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);
  sequence s_sw_go;
    reg_req.wr && reg_req.addr == 2'h0 && reg_req.wdata[6:4] == 3'h1 &&
      reg_req.wdata[2:0] == 3'h0 && !conv_active_bit;
  endsequence
  sequence s_started;
    convert_start && conv_active_bit;
  endsequence
  a_sw_start: assert property (s_sw_go |=> s_started) else $error("no sw start");
  a_done_fall: assert property ($fell(conv_active_bit) |-> $past(conv_finished))
    else $error("busy fell early");
  a_busy_end: assert property (conv_active_bit && conv_finished |=> !conv_active_bit)
    else $error("busy stuck");
  a_start_pulse: assert property (convert_start |-> conv_active_bit ##1 !convert_start)
    else $error("bad start pulse");
  a_track_len: assert property (convert_start && $past(conv_active_bit) |-> ticks_q == 3'h3)
    else $error("track length");
  a_lp_track: assert property ($rose(conv_active_bit) && !convert_start |-> track_q_out)
    else $error("no tracking");
  a_read_busy: assert property (reg_req.rd && reg_req.addr == 2'h0
    |=> reg_rdata[4] == $past(conv_active_bit)) else $error("busy read");
  a_read_idle: assert property (!reg_req.rd |=> reg_rdata == 8'h00) else $error("rdata");
endmodule : adc_start_checker

// [test/far_side_model.sv]
`timescale 1ns/100ps
module far_side_model
(
  input wire logic core_clk,
  input wire logic [3:0] ovf_req,
  input wire logic strobe_req,
  output adc_start_pkg::timer_ovf_t timer_ovf,
  output logic ext_convert_strobe
);
  always_ff @(posedge core_clk) timer_ovf <= adc_start_pkg::timer_ovf_t'(ovf_req);
  // Pin moves off the clock grid to exercise the synchroniser
  initial ext_convert_strobe = 1'b1;
  always @(strobe_req) ext_convert_strobe <= #1.3 strobe_req;
endmodule : far_side_model

// [test/tb_top.sv]
`timescale 1ns/100ps
module tb_top;
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  adc_start_pkg::reg_req_t req = '0;
  adc_start_pkg::timer_ovf_t ovf;
  logic [7:0] rdata;
  logic [3:0] ovf_req = 4'h0;
  logic strobe_req = 1'b1;
  logic strobe, tick = 1'b0, fin_p = 1'b0, win_p = 1'b0, trk, cs, act;
  int n_fail = 0;
  int total_checks = 0;
  int n;
  logic [2:0] codes [4] = '{3'h1, 3'h2, 3'h3, 3'h5};
  logic [3:0] masks [4] = '{4'h8, 4'h2, 4'h4, 4'h1};
  always #2 core_clk = ~core_clk;
  always @(posedge core_clk) tick <= ~tick;
  adc_conversion_start_control adc_conversion_start_control_i (.core_clk(core_clk), .rst(rst),
    .reg_req(req), .reg_rdata(rdata), .timer_ovf(ovf), .ext_convert_strobe(strobe),
    .sar_clk_tick(tick), .conv_finished(fin_p), .window_hit(win_p), .track_q_out(trk),
    .convert_start(cs), .conv_active_bit(act));
  far_side_model far_side_model_i (.core_clk(core_clk), .ovf_req(ovf_req),
    .strobe_req(strobe_req), .timer_ovf(ovf), .ext_convert_strobe(strobe));
  task ck(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      n_fail++;
      $display("wrong value at %0t: got %h want %h", $time, got, exp);
    end
  endtask : ck
  task wr(input logic [1:0] a, input logic [7:0] d);
    @(posedge core_clk) req <= '{a, d, 1'b1, 1'b0};
    @(posedge core_clk) req.wr <= 1'b0;
    #1;
  endtask : wr
  task rd(input logic [1:0] a, input logic [7:0] exp);
    @(posedge core_clk) req <= '{a, 8'h00, 1'b0, 1'b1};
    @(posedge core_clk) req.rd <= 1'b0;
    #1 ck(rdata, exp);
  endtask : rd
  task fin;
    @(posedge core_clk) fin_p <= 1'b1;
    @(posedge core_clk) fin_p <= 1'b0;
    #1 ck(act, 0);
  endtask : fin
  task ws(input int lim);
    n = 0;
    while (cs !== 1'b1 && n < lim)
    begin
      @(posedge core_clk);
      #1 n++;
    end
  endtask : ws
  task t_sw;
    wr(2'h0, 8'h10);
    ck(8'({trk, cs, act}), 8'h03);
    rd(2'h0, 8'h10);
    fin;
    rd(2'h0, 8'h20);
    @(posedge core_clk) win_p <= 1'b1;
    @(posedge core_clk) win_p <= 1'b0;
    rd(2'h0, 8'h28);
    wr(2'h1, 8'h20);
    rd(2'h0, 8'h08);
    wr(2'h1, 8'h08);
    wr(2'h3, 8'hFF);
    rd(2'h2, 8'h00);
    rd(2'h0, 8'h00);
    wr(2'h0, 8'h01);
    wr(2'h0, 8'h11);
    ck(act, 0);
    wr(2'h0, 8'h00);
    ck(act, 0);
  endtask : t_sw
  task t_timers;
    for (int m = 0; m < 2; m++)
      for (int i = 0; i < 4; i++)
      begin
        wr(2'h0, {1'b0, m[0], 3'h0, codes[i]});
        @(posedge core_clk) ovf_req <= masks[i];
        @(posedge core_clk) ovf_req <= 4'h0;
        ws(20);
        ck(cs, 1);
        ck(8'(n > 3), 8'(m));
        fin;
      end
    for (int c = 6; c < 8; c++)
    begin
      wr(2'h0, 8'(c));
      @(posedge core_clk) ovf_req <= 4'hF;
      @(posedge core_clk) ovf_req <= 4'h0;
      repeat (4) @(posedge core_clk);
      #1 ck(act, 0);
    end
  endtask : t_timers
  task t_strobe;
    wr(2'h0, 8'h44);
    @(posedge core_clk) strobe_req <= 1'b0;
    repeat (6) @(posedge core_clk);
    #1 ck(8'({trk, act}), 8'h02);
    @(posedge core_clk) strobe_req <= 1'b1;
    ws(8);
    ck(cs, 1);
    fin;
    repeat (8) @(posedge core_clk);
    #1 ck(8'({trk, act}), 8'h00);
  endtask : t_strobe
  task stop_test;
    if (n_fail == 0 && total_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : stop_test
  initial
  begin
    repeat (8) @(posedge core_clk);
    rst <= 1'b0;
    t_sw;
    t_timers;
    t_strobe;
    stop_test;
  end
  // Run needs under a thousand cycles
  initial
  begin
    #20000;
    n_fail++;
    stop_test;
  end
endmodule : tb_top
bind adc_conversion_start_control adc_start_checker adc_start_checker_i (.core_clk(core_clk),
  .rst(rst), .reg_req(reg_req), .reg_rdata(reg_rdata), .timer_ovf(timer_ovf),
  .ext_convert_strobe(ext_convert_strobe), .sar_clk_tick(sar_clk_tick),
  .conv_finished(conv_finished), .window_hit(window_hit), .track_q_out(track_q_out),
  .convert_start(convert_start), .conv_active_bit(conv_active_bit));
